// *** dv/art_checker.sv ***
// port-level assertions of the timer
// assumes bind onto the timer top, one clock domain
`timescale 1ns/1ps
module art_checker import art_pkg::*; (
	input wire logic ref_clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in, wb_dat_out,
	input wire logic wb_ack_out, halt_in, overflow_irq_out, wake_out,
	input wire logic [NUM_PWM-1:0] pwm_output_pin_out, pwm_output_pin_oe_out,
	input wire logic [NUM_CAP-1:0] capture_irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// a request taken this edge, word address
	wire tk = wb_cyc_in & wb_stb_in & !wb_ack_out;
	wire [5:0] wa = wb_adr_in[7:2];
	property p_ack; tk |=> wb_ack_out ##1 !wb_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_dat; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
	a_dat: assert property (p_dat) else $error("data off ack");
	property p_off; (pwm_output_pin_out & ~pwm_output_pin_oe_out) == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("disabled pin");
	property p_oe; tk && wb_we_in && wb_sel_in[0] && wa == 6'h3 |=>
		pwm_output_pin_oe_out == $past(wb_dat_in[7:4]); endproperty
	a_oe: assert property (p_oe) else $error("enable write");
	property p_wake; wake_out == (halt_in && |capture_irq_out); endproperty
	a_wake: assert property (p_wake) else $error("wake level");
	property p_cap; capture_irq_out[0] && !(tk && (wa == 6'h9 ||
		(wb_we_in && wa == 6'h8))) |=> capture_irq_out[0]; endproperty
	a_cap: assert property (p_cap) else $error("capture irq drop");
	property p_ovf; overflow_irq_out && !(tk && wa == 6'h0) |=>
		overflow_irq_out; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow irq drop");
	property p_halt; halt_in |=> $stable(pwm_output_pin_out); endproperty
	a_halt: assert property (p_halt) else $error("pwm moved in halt");
	c_ovf: cover property (overflow_irq_out);
	c_wake: cover property (wake_out);
	c_cap: cover property (tk && wa == 6'h9);
endmodule // art_checker

// *** dv/art_pins.sv ***
// pin-side model: bursts of pulses on the external clock pin
// assumes go_in is a one-cycle request on ref_clk_in
`timescale 1ns/1ps
module art_pins (
	input wire logic ref_clk_in,
	input wire logic [7:0] n_in,
	input wire logic go_in,
	output logic pin_out,
	output logic busy_out
);
	logic [7:0] left_q = 8'h00;
	logic [2:0] ph_q = 3'h0;
	// 4 high, 4 low per event so the synchroniser sees each rise
	always_ff @(posedge ref_clk_in) begin
		if (go_in) begin
			left_q <= n_in;
			ph_q <= 3'h0;
		end else if (left_q != 8'h00) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7) left_q <= left_q - 8'h01;
		end
	end
	// pin rests low between bursts
	assign pin_out = (left_q != 8'h00) && !ph_q[2];
	assign busy_out = left_q != 8'h00;
endmodule // art_pins

// *** dv/test_pwm_auto_reload_timer.sv ***
// self-checking bench of the timer over classic wishbone
// assumes art_pins drives the external clock pin
`timescale 1ns/1ps
module test_pwm_auto_reload_timer import art_pkg::*;;
	logic ref_clk_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0;
	logic halt = 0, go = 0, ack, oirq, wake, ep, busy;
	logic [7:0] adr = 0, n = 0, v;
	logic [3:0] sel = 4'hF, pwm, oe;
	logic [31:0] wd = 0, rd, eq[$], mq[$];
	logic [1:0] cap = 0, cirq;
	int fails = 0, num_checks = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	pwm_auto_reload_timer i_pwm_auto_reload_timer (.ref_clk_in, .rst_n_in,
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack),
		.halt_in(halt), .ext_clock_pin_in(ep), .capture_input_pin_in(cap),
		.pwm_output_pin_out(pwm), .pwm_output_pin_oe_out(oe),
		.overflow_irq_out(oirq), .capture_irq_out(cirq), .wake_out(wake));
	art_pins i_art_pins (.ref_clk_in, .n_in(n), .go_in(go), .pin_out(ep),
		.busy_out(busy));
	task automatic chk(input logic [31:0] g, e, input string s);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t %s", $time, s);
		end
	endtask
	// one classic cycle; expected read data goes in the queue
	task automatic bus(input logic w, input logic [7:0] a, d,
		input logic [31:0] e = 0, m = 0);
		eq.push_back(e);
		mq.push_back(m);
		@(posedge ref_clk_in);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= {24'h0, d};
		do @(posedge ref_clk_in); while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask
	// every ack retires the oldest expectation
	always @(posedge ref_clk_in) if (ack === 1'b1) begin
		chk(rd & mq.pop_front(), eq.pop_front(), "read data");
	end
	task automatic close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// watchdog well above the longest prescaled overflow that test 3 can wait for
	initial begin
		#300000;
		fails++;
		close_out;
	end
	initial begin
		v = $urandom(97934);
		repeat (4) @(posedge ref_clk_in);
		rst_n_in <= 1;
		bus(0, 8'h00, 0, 0, 32'hFFFFFFFF);
		bus(0, 8'h04, 0, 0, 32'hFFFFFFFF);
		bus(0, 8'h3C, 0, 0, 32'hFFFFFFFF);
		$display("test 1 done");
		v = $urandom;
		bus(1, 8'h04, v);
		bus(0, 8'h04, 0, v, 32'hFF);
		bus(1, 8'h08, 8'hF0);
		bus(1, 8'h00, 8'h04);
		bus(0, 8'h04, 0, 32'hF0, 32'hFF);
		$display("test 2 done");
		v = $urandom;
		bus(1, 8'h10, 8'hF8);
		bus(1, 8'h0C, {4'hF, v[3:0]});
		bus(1, 8'h04, 8'hFC);
		bus(1, 8'h00, {1'b0, v[6:4], 4'hA});
		chk(oe, 4'hF, "enable");
		while (oirq !== 1'b1) @(posedge ref_clk_in);
		halt <= 1;
		repeat (20) @(posedge ref_clk_in);
		halt <= 0;
		bus(1, 8'h00, 8'h02);
		bus(0, 8'h00, 0, 32'h03, 32'hFF);
		bus(0, 8'h00, 0, 32'h02, 32'hFF);
		$display("test 3 done");
		bus(1, 8'h04, 0);
		repeat (2) @(posedge ref_clk_in);
		chk(pwm, {28'h0, ~v[3:0]}, "pwm level");
		bus(1, 8'h00, 8'h88);
		n <= 5;
		go <= 1;
		@(posedge ref_clk_in);
		go <= 0;
		@(posedge ref_clk_in);
		while (busy === 1'b1) @(posedge ref_clk_in);
		repeat (4) @(posedge ref_clk_in);
		bus(0, 8'h04, 0, 32'h05, 32'hFF);
		$display("test 4 done");
		bus(1, 8'h20, 8'h05);
		cap <= 2'b01;
		while (cirq[0] !== 1'b1) @(posedge ref_clk_in);
		bus(1, 8'h04, 8'h33);
		cap <= 2'b00;
		repeat (6) @(posedge ref_clk_in);
		cap <= 2'b01;
		bus(1, 8'h00, 8'h80);
		halt <= 1;
		repeat (8) @(posedge ref_clk_in);
		chk(wake, 1, "wake");
		halt <= 0;
		bus(0, 8'h24, 0, 32'h05, 32'hFF);
		bus(0, 8'h20, 0, 32'h05, 32'h3F);
		$display("test 5 done");
		close_out;
	end
endmodule // test_pwm_auto_reload_timer
bind pwm_auto_reload_timer art_checker i_art_checker (.*);

// *** rtl/art_consts.svh ***
// register offsets, field positions and reset values of the auto-reload timer
// assumes a 32-bit classic wishbone slave; byte offsets, low byte carries data
//
// Functional notes
// R01 - counter increments once per prescaler output tick
// R02 - overflow reloads counter from auto_reload_value; prescaler keeps running
// R03 - counter_access reads or writes the counter on the fly
// R04 - prescale_select n divides the input clock by two to the n
// R05 - ext_clock_select picks cpu clock or the external clock pin
// R06 - counter_run_enable low freezes prescaler and counter
// R07 - reset clears counter, prescaler and selects the cpu clock
// R08 - force_reload or counter_access write loads counter and clears prescaler
// R09 - prescaler is never visible to software
// R10 - four compare shadows reload from duty_value at each overflow
// R11 - channel_output_enable drives each pwm pin independently
// R12 - all channels share period 256 minus auto_reload_value counts
// R13 - overflow sets pin per polarity, compare match restores other level
// R14 - software keeps duty values above the auto-reload value
// R15 - pwm generation stops while the system is halted
// R16 - overflow sets overflow_flag, interrupt when overflow_irq_enable set
// R17 - external event mode counts pin edges until overflow_flag
// R18 - software clears counter_run_enable before halt with external clock
// R19 - selected capture edge copies counter to capture_value, sets capture_flag
// R20 - capture_value is locked until read; the read clears capture_flag
// R21 - capture interrupt stands while capture_flag and capture_irq_enable set
// R22 - capture inputs act as edge interrupts and wake from halt
// R23 - reading timer_control_status clears overflow_flag
// R24 - polarity change inverts the pwm pin at once
`ifndef ART_CONSTS_SVH
`define ART_CONSTS_SVH

// byte offsets on the bus
`define OFF_CTRL_STATUS 8'h00
`define OFF_COUNTER 8'h04
`define OFF_RELOAD 8'h08
`define OFF_PWM_CTRL 8'h0C
`define OFF_DUTY0 8'h10
`define OFF_CAP_CTRL 8'h20
`define OFF_CAP_VAL0 8'h24

// timer_control_status fields
`define CSR_EXT_CLOCK_SELECT 7
`define CSR_PSEL_HI 6
`define CSR_PSEL_LO 4
`define CSR_TCE 3
`define CSR_FORCE_RELOAD 2
`define CSR_OIE 1
`define CSR_OVF 0

// capture_control_status fields: edge select, irq enable, flags
`define CAP_EDGE_LO 0
`define CAP_IE_LO 2
`define CAP_FLAG_LO 4

`define CNT_MAX 8'hFF
`define PRESC_RESET 7'h00

`endif

// *** rtl/art_pkg.sv ***
// types of the auto-reload pwm timer: the whole register state as one struct
// assumes art_consts.svh supplies offsets and field positions
package art_pkg;

	localparam int NUM_PWM = 4;
	localparam int NUM_CAP = 2;

	typedef struct packed {
		logic [7:0] cnt;
		logic [6:0] presc;
		logic [7:0] arr;
		logic ext_clock_select;
		logic [2:0] psel;
		logic counter_run_enable;
		logic overflow_irq_enable;
		logic ovf;
		logic [NUM_PWM-1:0] oe;
		logic [NUM_PWM-1:0] op;
		logic [NUM_PWM-1:0][7:0] duty;
		logic [NUM_PWM-1:0][7:0] shadow;
		logic [NUM_PWM-1:0] pwm;
		logic [NUM_CAP-1:0] cap_edge;
		logic [NUM_CAP-1:0] cap_ie;
		logic [NUM_CAP-1:0] cap_flag;
		logic [NUM_CAP-1:0][7:0] cap_val;
		logic [2:0] ext_sync;
		logic [NUM_CAP-1:0][2:0] cap_sync;
		logic ack;
		logic [31:0] rdat;
	} art_state_s;

endpackage

// *** rtl/pwm_auto_reload_timer.sv ***
// 8-bit auto-reload pwm timer with prescaler, four pwm channels, two captures
// assumes a classic wishbone master on ref_clk_in; pins are asynchronous
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "art_consts.svh"

module pwm_auto_reload_timer
	import art_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic halt_in,
	input wire logic ext_clock_pin_in,
	input wire logic [NUM_CAP-1:0] capture_input_pin_in,
	output logic [NUM_PWM-1:0] pwm_output_pin_out,
	output logic [NUM_PWM-1:0] pwm_output_pin_oe_out,
	output logic overflow_irq_out,
	output logic [NUM_CAP-1:0] capture_irq_out,
	output logic wake_out
);

	art_state_s s_q;
	art_state_s s_d;

	// true when the low n prescaler bits are all ones: the 2^n tap fires
	function automatic logic tap_hit(input logic [6:0] presc,
		input logic [2:0] n);
		logic [7:0] mask;
		mask = (8'h01 << n) - 8'h01;
		return ({1'b0, presc} & mask) == mask;
	endfunction

	// word decode against a byte offset
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction

	logic acc;
	logic wr;
	logic rd;
	logic ext_rise;
	logic in_tick;
	logic cnt_tick;
	logic ovf_ev;
	logic cap_ev;
	logic cap_rise;
	logic [7:0] duty_off;
	logic [7:0] cap_off;

	// next state: synchronisers, prescaler, counter, pwm, captures and bus
	always_comb begin
		s_d = s_q;
		acc = wb_cyc_in & wb_stb_in & ~s_q.ack;
		wr = acc & wb_we_in & wb_sel_in[0];
		rd = acc & ~wb_we_in;
		s_d.ack = acc;
		cap_ev = 1'b0;
		cap_rise = 1'b0;
		duty_off = 8'h00;
		cap_off = 8'h00;

		// pins pass two flops; the third only feeds the edge detector
		s_d.ext_sync = {s_q.ext_sync[1:0], ext_clock_pin_in};
		for (int i = 0; i < NUM_CAP; i++) begin
			s_d.cap_sync[i] = {s_q.cap_sync[i][1:0], capture_input_pin_in[i]};
		end
		ext_rise = s_q.ext_sync[1] & ~s_q.ext_sync[2];

		// input clock: cpu clock (stopped in halt) or external edges
		in_tick = s_q.counter_run_enable & (s_q.ext_clock_select ? ext_rise : ~halt_in); // R05 R06 R17
		cnt_tick = in_tick & tap_hit(s_q.presc, s_q.psel); // R04
		ovf_ev = cnt_tick & (s_q.cnt == `CNT_MAX);
		if (in_tick) begin
			s_d.presc = s_q.presc + 7'h01; // R06
		end
		if (cnt_tick) begin
			// prescaler is left alone on reload
			s_d.cnt = ovf_ev ? s_q.arr : s_q.cnt + 8'h01; // R01 R02 R12
		end

		// overflow: flag and duty double buffering
		if (ovf_ev) begin
			s_d.ovf = 1'b1; // R16 R17
			s_d.shadow = s_q.duty; // R10
		end else if (rd && hit(wb_adr_in, `OFF_CTRL_STATUS)) begin
			s_d.ovf = 1'b0; // R23
		end

		// captures: a pending flag locks the value until it is read
		for (int i = 0; i < NUM_CAP; i++) begin
			cap_rise = s_q.cap_sync[i][1] & ~s_q.cap_sync[i][2];
			cap_ev = s_q.cap_edge[i] ? cap_rise :
				(~s_q.cap_sync[i][1] & s_q.cap_sync[i][2]);
			cap_off = `OFF_CAP_VAL0 + 8'(i * 4);
			// a clearing read and a new edge in one cycle: the set wins
			if (rd && hit(wb_adr_in, cap_off)) begin
				s_d.cap_flag[i] = 1'b0; // R20
			end
			if (cap_ev && (!s_q.cap_flag[i] || (rd && hit(wb_adr_in, cap_off))))
				begin
				s_d.cap_val[i] = s_q.cnt; // R19
				s_d.cap_flag[i] = 1'b1; // R19 R22
			end
		end

		// register writes win over the counter tick in the same cycle
		if (wr) begin
			if (hit(wb_adr_in, `OFF_CTRL_STATUS)) begin
				s_d.ext_clock_select = wb_dat_in[`CSR_EXT_CLOCK_SELECT];
				s_d.psel = wb_dat_in[`CSR_PSEL_HI:`CSR_PSEL_LO];
				s_d.counter_run_enable = wb_dat_in[`CSR_TCE];
				s_d.overflow_irq_enable = wb_dat_in[`CSR_OIE];
				if (wb_dat_in[`CSR_FORCE_RELOAD]) begin
					s_d.cnt = s_q.arr; // R08
					s_d.presc = `PRESC_RESET; // R08
				end
			end
			if (hit(wb_adr_in, `OFF_COUNTER)) begin
				s_d.cnt = wb_dat_in[7:0]; // R03 R08
				s_d.presc = `PRESC_RESET; // R08
			end
			if (hit(wb_adr_in, `OFF_RELOAD)) begin
				s_d.arr = wb_dat_in[7:0];
			end
			if (hit(wb_adr_in, `OFF_PWM_CTRL)) begin
				s_d.oe = wb_dat_in[7:4];
				s_d.op = wb_dat_in[3:0];
			end
			for (int i = 0; i < NUM_PWM; i++) begin
				duty_off = `OFF_DUTY0 + 8'(i * 4);
				if (hit(wb_adr_in, duty_off)) begin
					s_d.duty[i] = wb_dat_in[7:0];
				end
			end
			if (hit(wb_adr_in, `OFF_CAP_CTRL)) begin
				s_d.cap_edge = wb_dat_in[`CAP_EDGE_LO +: NUM_CAP];
				s_d.cap_ie = wb_dat_in[`CAP_IE_LO +: NUM_CAP];
			end
		end

		// pwm level uses the enable and polarity being written this cycle,
		// so a disabled pin never shows a stale high level
		for (int i = 0; i < NUM_PWM; i++) begin
			s_d.pwm[i] = s_d.oe[i] & (halt_in ? s_q.pwm[i] :
				((s_q.cnt <= s_q.shadow[i]) ^ s_d.op[i])); // R11 R13 R15 R24
		end

		// read data; force_reload reads zero and the prescaler has no port
		s_d.rdat = 32'h0000_0000; // R09
		if (rd) begin
			if (hit(wb_adr_in, `OFF_CTRL_STATUS)) begin
				s_d.rdat[7:0] = {s_q.ext_clock_select, s_q.psel, s_q.counter_run_enable, 1'b0,
					s_q.overflow_irq_enable, s_q.ovf};
			end
			if (hit(wb_adr_in, `OFF_COUNTER)) begin
				s_d.rdat[7:0] = s_q.cnt; // R03
			end
			if (hit(wb_adr_in, `OFF_RELOAD)) begin
				s_d.rdat[7:0] = s_q.arr;
			end
			if (hit(wb_adr_in, `OFF_PWM_CTRL)) begin
				s_d.rdat[7:0] = {s_q.oe, s_q.op};
			end
			for (int i = 0; i < NUM_PWM; i++) begin
				duty_off = `OFF_DUTY0 + 8'(i * 4);
				if (hit(wb_adr_in, duty_off)) begin
					s_d.rdat[7:0] = s_q.duty[i];
				end
			end
			if (hit(wb_adr_in, `OFF_CAP_CTRL)) begin
				s_d.rdat[`CAP_EDGE_LO +: NUM_CAP] = s_q.cap_edge;
				s_d.rdat[`CAP_IE_LO +: NUM_CAP] = s_q.cap_ie;
				s_d.rdat[`CAP_FLAG_LO +: NUM_CAP] = s_q.cap_flag;
			end
			for (int i = 0; i < NUM_CAP; i++) begin
				cap_off = `OFF_CAP_VAL0 + 8'(i * 4);
				if (hit(wb_adr_in, cap_off)) begin
					s_d.rdat[7:0] = s_q.cap_val[i];
				end
			end
		end
	end

	// single state register; reset gives cpu clock, stopped, all clear
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			s_q <= '0; // R07
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state, wake_out also gated by halt_in; requests are levels while flags stand
	assign wb_dat_out = s_q.rdat;
	assign wb_ack_out = s_q.ack;
	assign pwm_output_pin_out = s_q.pwm;
	assign pwm_output_pin_oe_out = s_q.oe; // R11
	assign overflow_irq_out = s_q.ovf & s_q.overflow_irq_enable; // R16
	assign capture_irq_out = s_q.cap_flag & s_q.cap_ie; // R21 R22
	assign wake_out = halt_in & (|(s_q.cap_flag & s_q.cap_ie)); // R22

endmodule // pwm_auto_reload_timer
